// ===== design/timer_compare_pwm.sv
// Purpose: Six-channel 16-bit timer compare and PWM block with register port
// Assumes: 8-bit register port, read data one cycle after the read strobe
// Notes:   Input capture is not built; mode 0:0 leaves a channel idle
// Notes on behaviour
// RQ1: Unbuffered compare value written over the active register acts at once.
// RQ2: Compare fires only on equality; a passed value is missed that period.
// RQ3: Software lowers an unbuffered value inside the channel compare interrupt.
// RQ4: Software raises an unbuffered value inside the overflow interrupt.
// RQ5: Channel event at end of compare pulse, overflow event at period end.
// RQ6: Pair 0/1 buffer bit links channels onto pin 0; channel 0 starts.
// RQ7: Write to inactive partner takes control at next overflow; last written wins.
// RQ8: Pair 2/3 buffer bit links channels onto pin 2; channel 2 starts.
// RQ9: Pair 4/5 buffer bit links channels onto pin 4; channel 4 starts.
// RQ10: Linked pair uses even control register; odd pin released.
// RQ11: Software writes only the inactive set; active writes act unbuffered.
// RQ12: Toggle-on-overflow flips the pin at modulo match; period is overflow spacing.
// RQ13: Compare clears pin for active-high pulse, sets it for active-low.
// RQ14: Modulo 255 undivided gives a period of 256 bus clocks.
// RQ15: Compare 128 in 8-bit period gives half duty, 256 steps.
// RQ16: Software shortens PWM width inside the channel compare interrupt.
// RQ17: Software lengthens PWM width inside the overflow interrupt.
// RQ18: Software should not pick toggle-on-compare for PWM.
// RQ19: Three-bit prescale picks seven divided bus rates or the external pin.
// RQ20: Overflow flag on wrap after modulo match; channel flag per compare; enables.
// RQ21: Mode 0:1 unbuffered, 1:0 buffered; edge code 1:0 clears, 1:1 sets.
// RQ22: No overflow toggle gives 0% duty; max-duty bit then gives 100%.
// RQ23: Match when counter equals active compare on a tick; action same cycle.
`timescale 1ns/1ns
`include "timer_cmp_map.svh"
module timer_compare_pwm
    import timer_cmp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       ext_clk_pin,
    output logic      [5:0] chan_pin_out,
    output logic      [5:0] chan_pin_oe_n,
    output logic            overflow_irq,
    output logic      [5:0] chan_irq
);
    // ********************************
    // Declarations
    // ********************************
    logic [5:0]  div_q, div_d;
    word_t       cnt_q, cnt_d;
    logic        ext_s1_q, ext_s2_q, ext_s3_q;
    logic        tick;
    logic        ovf_evt;
    logic        trst_wr;

    logic        ovf_flag_q, ovf_flag_d;
    logic        ovf_ie_q, ovf_ie_d;
    logic        stop_q, stop_d;
    logic [2:0]  ps_q, ps_d;
    word_t       mod_q, mod_d;
    word_t       cmp_q [6];
    word_t       cmp_d [6];
    logic [6:0]  csc_q [6];
    logic [6:0]  csc_d [6];
    logic [5:0]  chflag_q, chflag_d;
    logic [2:0]  active_sel_q, active_sel_d;
    logic [2:0]  last_wr_q, last_wr_d;

    logic [7:0]  rdata_d;
    logic        ovf_irq_d;
    logic [5:0]  chan_irq_d;
    logic [5:0]  oe_n_d;

    chan_dec_t   wdec, rdec;
    logic [2:0]  link_v;
    logic [5:0]  en_v;
    logic [5:0]  match_v;
    pin_action_t act_v [6];
    word_t       cmp_act [6];

    chan_if cif [6] ();

    // Finds which channel group and which byte an address selects
    function automatic chan_dec_t chan_decode(input logic [7:0] a);
        chan_dec_t r;
        r = '0;
        for (int i = 0; i < 6; i++) begin
            for (int s = 0; s < 3; s++) begin
                if (a == 8'(`CH_BASE_ADDR + `CH_STRIDE * i + s)) begin
                    r.hit = 1'b1;
                    r.ch  = 3'(i);
                    r.sel = 2'(s);
                end
            end
        end
        return r;
    endfunction

    // Divide-by-2^ps enable from the free-running divider
    function automatic logic prescale_tick(input logic [2:0] ps, input logic [5:0] div);
        logic [5:0] m;
        m = 6'((7'h01 << ps) - 7'h01);
        return (div & m) == m;
    endfunction

    assign wdec    = chan_decode(addr);
    assign rdec    = chan_decode(addr);
    assign trst_wr = wr_en && (addr == `TSC_ADDR) && wdata[`TSC_RST_BIT];

    // ********************************
    // Timebase: prescaler and counter
    // ********************************
    // Tick, overflow and next counter value
    always_comb begin
        if (ps_q == `PS_EXT) tick = ext_s2_q & ~ext_s3_q; // RQ19
        else tick = prescale_tick(ps_q, div_q); // RQ19 RQ14
        tick    = tick & ~stop_q;
        ovf_evt = tick && (cnt_q == mod_q); // RQ20
        div_d   = div_q + 6'h01;
        cnt_d   = cnt_q;
        if (tick) cnt_d = ovf_evt ? 16'h0000 : cnt_q + 16'h0001; // RQ14
        // Counter reset also restarts the divider so the first period is whole
        if (trst_wr) begin
            div_d = 6'h00;
            cnt_d = 16'h0000;
        end
    end

    // Timebase registers; pin edge is read only after two stages
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_q    <= 6'h00;
            cnt_q    <= 16'h0000;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            div_q    <= div_d;
            cnt_q    <= cnt_d;
            ext_s1_q <= ext_clk_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // ********************************
    // Register file, flags and pair handover
    // ********************************
    // Writes first, then hardware sets, so a set beats a same-cycle clear
    always_comb begin
        ovf_flag_d   = ovf_flag_q;
        ovf_ie_d     = ovf_ie_q;
        stop_d       = stop_q;
        ps_d         = ps_q;
        mod_d        = mod_q;
        cmp_d        = cmp_q;
        csc_d        = csc_q;
        chflag_d     = chflag_q;
        last_wr_d    = last_wr_q;
        active_sel_d = active_sel_q;
        if (wr_en && addr == `TSC_ADDR) begin
            if (!wdata[`TSC_FLAG_BIT]) ovf_flag_d = 1'b0;
            ovf_ie_d = wdata[`TSC_IE_BIT];
            stop_d   = wdata[`TSC_STOP_BIT];
            ps_d     = wdata[2:0];
        end
        if (wr_en && addr == `MOD_HI_ADDR) mod_d[15:8] = wdata;
        if (wr_en && addr == `MOD_LO_ADDR) mod_d[7:0] = wdata;
        if (wr_en && wdec.hit) begin
            unique case (wdec.sel)
                `SEL_SC: begin
                    csc_d[wdec.ch] = wdec.ch[0] ? (wdata[6:0] & `CSC_ODD_MASK)
                                                : wdata[6:0];
                    if (!wdata[`CSC_FLAG_BIT]) chflag_d[wdec.ch] = 1'b0;
                end
                `SEL_HI: cmp_d[wdec.ch][15:8] = wdata; // RQ1
                default: cmp_d[wdec.ch][7:0] = wdata; // RQ1
            endcase
            // Remember which set of the pair was written last
            if (wdec.sel != `SEL_SC) last_wr_d[wdec.ch[2:1]] = wdec.ch[0]; // RQ7
        end
        if (ovf_evt) ovf_flag_d = 1'b1; // RQ5 RQ20
        chflag_d = chflag_d | match_v; // RQ5 RQ20
        for (int p = 0; p < 3; p++) begin
            if (ovf_evt) active_sel_d[p] = last_wr_d[p]; // RQ7
            // Unlinked pairs fall back to the even set
            if (!link_v[p]) begin
                active_sel_d[p] = 1'b0; // RQ6 RQ8 RQ9
                last_wr_d[p]    = 1'b0;
            end
        end
    end

    // Register file flip-flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ovf_flag_q   <= 1'b0;
            ovf_ie_q     <= 1'b0;
            stop_q       <= `TSC_STOP_RESET;
            ps_q         <= 3'h0;
            mod_q        <= `MOD_RESET;
            chflag_q     <= 6'h00;
            active_sel_q <= 3'h0;
            last_wr_q    <= 3'h0;
            for (int i = 0; i < 6; i++) begin
                cmp_q[i] <= 16'h0000;
                csc_q[i] <= `CSC_RESET;
            end
        end else begin
            ovf_flag_q   <= ovf_flag_d;
            ovf_ie_q     <= ovf_ie_d;
            stop_q       <= stop_d;
            ps_q         <= ps_d;
            mod_q        <= mod_d;
            chflag_q     <= chflag_d;
            active_sel_q <= active_sel_d;
            last_wr_q    <= last_wr_d;
            cmp_q        <= cmp_d;
            csc_q        <= csc_d;
        end
    end

    // ********************************
    // Channels
    // ********************************
    for (genvar p = 0; p < 3; p++) begin : g_pair
        assign link_v[p] = csc_q[2*p][`CSC_MSHI_BIT]; // RQ6 RQ8 RQ9 RQ21
    end

    for (genvar i = 0; i < 6; i++) begin : g_chan
        if (i % 2 == 0) begin : g_even
            // Active set of a pair; writing it acts like unbuffered compare
            assign cmp_act[i] = (link_v[i/2] && active_sel_q[i/2]) ? cmp_q[i+1]
                                                                    : cmp_q[i]; // RQ7 RQ11
            assign en_v[i] = csc_q[i][`CSC_MSHI_BIT] | csc_q[i][`CSC_MSLO_BIT]; // RQ21
        end else begin : g_odd
            assign cmp_act[i] = cmp_q[i];
            // Odd half of a linked pair goes quiet and frees its pin
            assign en_v[i] = csc_q[i][`CSC_MSLO_BIT] & ~link_v[i/2]; // RQ10
        end
        // Channels see the count being loaded, so a pin edge lands as the counter reaches it
        assign act_v[i]       = pin_action_t'(csc_q[i][`CSC_ELHI_BIT:`CSC_ELLO_BIT]); // RQ21
        assign cif[i].tick    = tick;
        assign cif[i].ovf     = ovf_evt;
        assign cif[i].cnt     = cnt_d; // RQ15 RQ23
        assign cif[i].cmp     = cmp_act[i]; // RQ15 RQ23
        assign cif[i].enable  = en_v[i];
        assign cif[i].act     = act_v[i];
        assign cif[i].tov     = csc_q[i][`CSC_TOV_BIT];
        assign cif[i].max     = csc_q[i][`CSC_MAX_BIT];
        assign match_v[i]     = cif[i].match_evt;
        assign chan_pin_out[i] = cif[i].pin_q;

        compare_channel u_chan (
            .clk   (clk),
            .reset (reset),
            .ch    (cif[i])
        );
    end

    // ********************************
    // Read data, requests and pin enables
    // ********************************
    // Read data shows only in the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (rd_en) begin
            if (addr == `TSC_ADDR) rdata_d = {ovf_flag_q, ovf_ie_q, stop_q, 2'b00, ps_q};
            else if (addr == `CNT_HI_ADDR) rdata_d = cnt_q[15:8];
            else if (addr == `CNT_LO_ADDR) rdata_d = cnt_q[7:0];
            else if (addr == `MOD_HI_ADDR) rdata_d = mod_q[15:8];
            else if (addr == `MOD_LO_ADDR) rdata_d = mod_q[7:0];
            else if (rdec.hit) begin
                unique case (rdec.sel)
                    `SEL_SC: rdata_d = {chflag_q[rdec.ch], csc_q[rdec.ch]};
                    `SEL_HI: rdata_d = cmp_q[rdec.ch][15:8];
                    default: rdata_d = cmp_q[rdec.ch][7:0];
                endcase
            end
        end
        ovf_irq_d = ovf_flag_d & ovf_ie_d; // RQ20
        for (int i = 0; i < 6; i++) begin
            chan_irq_d[i] = chflag_d[i] & csc_d[i][`CSC_IE_BIT]; // RQ20
            oe_n_d[i]     = ~(en_v[i] && act_v[i] != act_none); // RQ10
        end
    end

    // Output flip-flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata         <= 8'h00;
            overflow_irq  <= 1'b0;
            chan_irq      <= 6'h00;
            chan_pin_oe_n <= 6'h3f;
        end else begin
            rdata         <= rdata_d;
            overflow_irq  <= ovf_irq_d;
            chan_irq      <= chan_irq_d;
            chan_pin_oe_n <= oe_n_d;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence ovf_s;
        tick && (cnt_q == mod_q) && !trst_wr;
    endsequence
    sequence step_s;
        tick && (cnt_q != mod_q) && !trst_wr;
    endsequence

    counter_wrap_a: assert property ( // RQ20
        ovf_s |=> cnt_q == 16'h0000 && ovf_flag_q)
        else $error("counter did not wrap with overflow flag");
    counter_step_a: assert property ( // RQ14
        step_s |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not advance by one");
    undiv_tick_a: assert property ( // RQ14
        ps_q == 3'h0 && !stop_q && !wr_en |=> tick)
        else $error("undivided prescale missed a tick");
    direct_write_a: assert property ( // RQ1
        wr_en && addr == 8'h28 && !link_v[0] |=> cmp_act[0][7:0] == $past(wdata))
        else $error("unbuffered compare did not act at once");
    overflow_req_a: assert property ( // RQ20
        ovf_flag_q && ovf_ie_q && !wr_en |=> overflow_irq)
        else $error("overflow request missing");
    handover_a: assert property ( // RQ7
        link_v[0] && ovf_evt && !wr_en |=> active_sel_q[0] == $past(last_wr_q[0]))
        else $error("pair did not hand over at overflow");

    for (genvar p = 0; p < 3; p++) begin : g_pair_chk
        unlinked_sel_a: assert property ( // RQ6 RQ8 RQ9
            !link_v[p] |=> active_sel_q[p] == 1'b0)
            else $error("unlinked pair not on even set");
        odd_release_a: assert property ( // RQ10
            link_v[p] |=> chan_pin_oe_n[2*p+1])
            else $error("odd pin of linked pair still driven");
    end
    for (genvar i = 0; i < 6; i++) begin : g_flag_chk
        chan_flag_a: assert property ( // RQ5
            match_v[i] |=> chflag_q[i])
            else $error("compare did not set channel flag");
    end
endmodule

// ===== pkg/timer_cmp_map.svh
// Purpose: Register offsets, field positions and reset values of the timer compare block
// Assumes: 8-bit register port, registers at their printed byte offsets
// Notes:   Definitions only
`ifndef TIMER_CMP_MAP_SVH
`define TIMER_CMP_MAP_SVH
// Register offsets
`define TSC_ADDR      8'h20
`define CNT_HI_ADDR   8'h22
`define CNT_LO_ADDR   8'h23
`define MOD_HI_ADDR   8'h24
`define MOD_LO_ADDR   8'h25
`define CH_BASE_ADDR  8'h26
`define CH_STRIDE     3
// Sub-register of a channel group
`define SEL_SC        2'h0
`define SEL_HI        2'h1
`define SEL_LO        2'h2
// Timer status/control fields
`define TSC_FLAG_BIT  7
`define TSC_IE_BIT    6
`define TSC_STOP_BIT  5
`define TSC_RST_BIT   4
// Channel status/control fields
`define CSC_FLAG_BIT  7
`define CSC_IE_BIT    6
`define CSC_MSHI_BIT  5
`define CSC_MSLO_BIT  4
`define CSC_ELHI_BIT  3
`define CSC_ELLO_BIT  2
`define CSC_TOV_BIT   1
`define CSC_MAX_BIT   0
`define CSC_ODD_MASK  7'h5f
// Reset values
`define TSC_STOP_RESET 1'b1
`define MOD_RESET      16'hffff
`define CSC_RESET      7'h00
// Prescaler code that selects the external clock pin
`define PS_EXT        3'h7
`endif

// ===== pkg/timer_cmp_pkg.sv
// Purpose: Types shared by the timer compare block
// Assumes: Nothing
// Notes:   Pin action codes follow the edge/level select field
package timer_cmp_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        act_none   = 2'b00,
        act_toggle = 2'b01,
        act_clear  = 2'b10,
        act_set    = 2'b11
    } pin_action_t;
    typedef struct packed {
        logic       hit;
        logic [2:0] ch;
        logic [1:0] sel;
    } chan_dec_t;
endpackage

// ===== pkg/chan_if.sv
// Purpose: Carries timebase and configuration to one compare channel
// Assumes: One clock domain
// Notes:   ctl side is the timer core, chan side the channel
`timescale 1ns/1ns
interface chan_if;
    import timer_cmp_pkg::*;
    logic        tick;
    logic        ovf;
    word_t       cnt;
    word_t       cmp;
    logic        enable;
    pin_action_t act;
    logic        tov;
    logic        max;
    logic        match_evt;
    logic        pin_q;
    modport ctl  (output tick, ovf, cnt, cmp, enable, act, tov, max,
                  input match_evt, pin_q);
    modport chan (input tick, ovf, cnt, cmp, enable, act, tov, max,
                  output match_evt, pin_q);
endinterface

// ===== design/compare_channel.sv
// Purpose: One output compare channel: equality match and pin action
// Assumes: tick is a one-cycle timer clock enable
// Notes:   Compare action is applied after the overflow toggle
`timescale 1ns/1ns
module compare_channel
    import timer_cmp_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    chan_if.chan      ch
);
    logic pin_d;
    logic pin_r;

    // ********************************
    // Match and pin action
    // ********************************
    // Equality only: a value passed over is simply missed
    assign ch.match_evt = ch.tick && ch.enable && (ch.cnt == ch.cmp); // RQ2 RQ23

    // Next pin level
    always_comb begin
        pin_d = pin_r;
        if (ch.enable) begin
            if (ch.max && !ch.tov) begin
                // Hold the pulse level for full duty
                if (ch.act == act_clear) pin_d = 1'b1; // RQ22
                else if (ch.act == act_set) pin_d = 1'b0; // RQ22
            end else begin
                if (ch.ovf && ch.tov) pin_d = ~pin_r; // RQ12
                if (ch.match_evt) begin
                    unique case (ch.act)
                        act_toggle: pin_d = ~pin_d;
                        act_clear:  pin_d = 1'b0; // RQ13
                        act_set:    pin_d = 1'b1; // RQ13
                        act_none:   pin_d = pin_d;
                    endcase
                end
            end
        end
    end

    // Pin register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) pin_r <= 1'b0;
        else pin_r <= pin_d;
    end
    assign ch.pin_q = pin_r;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence ovf_tog_s;
        ch.ovf && ch.tov && ch.enable && !ch.max;
    endsequence

    toggle_on_ovf_a: assert property ( // RQ12
        ovf_tog_s ##0 !ch.match_evt |=> pin_r == !$past(pin_r))
        else $error("pin did not toggle on overflow");
    clear_on_cmp_a: assert property ( // RQ13
        ch.match_evt && ch.act == act_clear && !ch.max |=> !pin_r)
        else $error("pin not cleared on compare");
    set_on_cmp_a: assert property ( // RQ13
        ch.match_evt && ch.act == act_set && !ch.max |=> pin_r)
        else $error("pin not set on compare");
    full_duty_a: assert property ( // RQ22
        ch.enable && ch.max && !ch.tov && ch.act == act_clear |=> pin_r)
        else $error("full duty level not held");
endmodule

// ===== test/pin_load_model.sv
// Purpose: Load on the six channel pins, seen from outside the block
// Assumes: Each pin has a pull-up; the block drives it while the enable is low
// Notes:   A released pin reads high, never the last driven value
`timescale 1ns/1ns
module pin_load_model (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe_n,
    output logic      [5:0] pin_level
);
    // ********************
    // Wire level
    // ********************
    // Pull-up wins where the block lets go, so a released odd pin reads high whatever it last drove
    assign pin_level = pin_oe_n | pin_out;
endmodule

// ===== test/timer_compare_pwm_tb.sv
// Purpose: Self-checking bench for the six-channel compare and PWM block
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Pulse widths are measured on the loaded pin levels, in clk cycles
`timescale 1ns/1ns
module timer_compare_pwm_tb;
    import timer_cmp_pkg::*;
    logic       clk         = 1'b0;
    logic       reset       = 1'b1;
    logic [7:0] addr        = 8'h00;
    logic [7:0] wdata       = 8'h00;
    logic       wr_en       = 1'b0;
    logic       rd_en       = 1'b0;
    logic       ext_clk_pin = 1'b0;
    logic [1:0] ext_div     = 2'h0;
    logic [7:0] rdata;
    logic [5:0] pin_out;
    logic [5:0] pin_oe_n;
    logic [5:0] lvl;
    logic       overflow_irq;
    logic [5:0] chan_irq;
    int         error_cnt   = 0;
    int         tests_run   = 0;
    int         hi;
    int         per;

    // ********************
    // Clocks and instances
    // ********************
    always #5 clk = ~clk;
    // External timer clock: toggles every 4 clk, a rising edge every 8 clk cycles
    always @(posedge clk) begin
        ext_div <= ext_div + 2'h1;
        if (ext_div == 2'h3) begin
            ext_clk_pin <= ~ext_clk_pin;
        end
    end

    timer_compare_pwm u_timer_compare_pwm (
        .clk           (clk),
        .reset         (reset),
        .addr          (addr),
        .wdata         (wdata),
        .wr_en         (wr_en),
        .rd_en         (rd_en),
        .rdata         (rdata),
        .ext_clk_pin   (ext_clk_pin),
        .chan_pin_out  (pin_out),
        .chan_pin_oe_n (pin_oe_n),
        .overflow_irq  (overflow_irq),
        .chan_irq      (chan_irq)
    );

    pin_load_model u_pin_load_model (
        .pin_out   (pin_out),
        .pin_oe_n  (pin_oe_n),
        .pin_level (lvl)
    );

    // ********************
    // Checks and bus tasks
    // ********************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            error_cnt++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk_reg(rdata, exp);
    endtask

    task automatic wrcmp(input int i, input logic [15:0] cmp);
        wr(8'h27 + 8'(3 * i), cmp[15:8]);
        wr(8'h28 + 8'(3 * i), cmp[7:0]);
    endtask

    task automatic setch(input int i, input logic [7:0] ctl, input logic [15:0] cmp);
        wrcmp(i, cmp);
        wr(8'h26 + 8'(3 * i), ctl);
    endtask

    // A wait that runs out of time is a mismatch, not a silent short count
    task automatic give_up(input int n);
        if (n >= 5000) begin
            error_cnt++;
            $display("[ERR] %0t wait limit reached", $time);
        end
    endtask

    // Bounded wait for a pin level; returns the cycles spent
    task automatic wait_lvl(input int i, input logic v, output int n);
        n = 0;
        while (lvl[i] !== v && n < 5000) begin
            @(negedge clk);
            n++;
        end
        give_up(n);
    endtask

    // Bounded wait for the overflow or channel 0 request, as an interrupt routine would
    task automatic wait_irq(input logic ovf);
        int n;
        n = 0;
        while ((ovf ? overflow_irq : chan_irq[0]) !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        give_up(n);
    endtask

    // One full pulse from rising edge to rising edge
    task automatic measure(input int i);
        int n;
        wait_lvl(i, 1'b0, n);
        wait_lvl(i, 1'b1, n);
        wait_lvl(i, 1'b0, hi);
        wait_lvl(i, 1'b1, n);
        per = hi + n;
    endtask

    task automatic window(input int i);
        hi = 0;
        repeat (256) begin
            @(negedge clk);
            if (lvl[i] === 1'b1) begin
                hi++;
            end
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ********************
    // Test sequence
    // ********************
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(8'h20, 8'h20);
        rd(8'h24, 8'hff);
        rd(8'h25, 8'hff);
        rd(8'h26, 8'h00);
        rd(8'h21, 8'h00);
        wr(8'h40, 8'h5a);
        rd(8'h40, 8'h00);
        wr(8'h29, 8'h20);
        rd(8'h29, 8'h00);
        chk_reg({2'b00, pin_oe_n}, 8'h3f);
        end_test("registers");
        // Stop and clear the counter, then an 8-bit period
        wr(8'h20, 8'h30);
        wr(8'h24, 8'h00);
        wr(8'h25, 8'hff);
        setch(0, 8'h1a, 16'h0080);
        wr(8'h20, 8'h40);
        measure(0);
        measure(0);
        chk_cnt(per, 256);
        chk_cnt(hi, 128);
        chk_reg({7'h00, overflow_irq}, 8'h01);
        rd(8'h20, 8'hc0);
        setch(0, 8'h1e, 16'h0040);
        measure(0);
        measure(0);
        chk_cnt(hi, 192);
        setch(0, 8'h18, 16'h0040);
        repeat (300) @(negedge clk);
        window(0);
        chk_cnt(hi, 0);
        setch(0, 8'h19, 16'h0040);
        repeat (300) @(negedge clk);
        window(0);
        chk_cnt(hi, 256);
        end_test("pwm");
        // Divided rate, then the external pin as timer clock
        setch(0, 8'h1a, 16'h0080);
        for (int k = 0; k < 2; k++) begin
            wr(8'h20, k ? 8'h07 : 8'h01);
            measure(0);
            measure(0);
            chk_cnt(per, k ? 2048 : 512);
        end
        wr(8'h20, 8'h00);
        end_test("prescaler");
        // Lower the compare value behind the counter: this period is missed
        setch(0, 8'h5a, 16'h0080);
        measure(0);
        repeat (50) @(negedge clk);
        wr(8'h26, 8'h5a);
        wr(8'h28, 8'h20);
        repeat (150) @(negedge clk);
        chk_reg({7'h00, chan_irq[0]}, 8'h00);
        chk_reg({7'h00, lvl[0]}, 8'h01);
        repeat (100) @(negedge clk);
        chk_reg({7'h00, chan_irq[0]}, 8'h01);
        chk_reg({7'h00, lvl[0]}, 8'h00);
        end_test("unbuffered");
        // Raise the width from the overflow routine: one clean period follows
        wr(8'h20, 8'h40);
        wait_irq(1'b1);
        wr(8'h20, 8'h00);
        wrcmp(0, 16'h00a0);
        measure(0);
        chk_cnt(hi, 160);
        // Lower the width from the compare routine, before the period ends
        wr(8'h26, 8'h5a);
        wait_irq(1'b0);
        wrcmp(0, 16'h0030);
        measure(0);
        chk_cnt(hi, 48);
        end_test("synced");
        // Each linked pair: even set first, then handover by last write
        for (int p = 0; p < 3; p++) begin
            // Odd channel drives its own pin until the pair is linked
            wr(8'h29 + 8'(6 * p), 8'h1a);
            setch(2 * p, 8'h2a, 16'h0040);
            measure(2 * p);
            measure(2 * p);
            chk_cnt(hi, 64);
            chk_reg({7'h00, pin_oe_n[2 * p + 1]}, 8'h01);
            wrcmp(2 * p + 1, 16'h00c0);
            measure(2 * p);
            measure(2 * p);
            chk_cnt(hi, 192);
            wrcmp(2 * p, 16'h0020);
            measure(2 * p);
            measure(2 * p);
            chk_cnt(hi, 32);
        end
        end_test("buffered");
        stop_test;
    end

    // Whole run is well under this many cycles
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test;
    end
endmodule
